//--- rtl/rgpms_pkg.sv
`default_nettype none
package rgpms_pkg;
    // slave-port address map
    localparam logic [15:0] ADDR_PLL_FIRST = 16'hf000;
    localparam logic [15:0] ADDR_PLL_LAST = 16'hf004;
    localparam logic [15:0] ADDR_CTRL_BASE = 16'hf000;
    localparam logic [15:0] ADDR_POWER_GATE_CLOCKS_PORTS_SRC = 16'hf050;
    localparam logic [15:0] ADDR_POWER_GATE_MIC_SPDIF_ADC = 16'hf051;
    localparam logic [15:0] ADDR_SEQ_STATUS = 16'hf0f0;

    // power-on defaults, a set bit keeps the block clocked
    localparam logic [15:0] RST_POWER_GATE_CLOCKS_PORTS_SRC = 16'h007f;
    localparam logic [15:0] RST_POWER_GATE_MIC_SPDIF_ADC = 16'h000f;
    localparam logic [15:0] MASK_POWER_GATE_CLOCKS_PORTS_SRC = 16'h007f;
    localparam logic [15:0] MASK_POWER_GATE_MIC_SPDIF_ADC = 16'h000f;

    // field positions of the first power gate register
    localparam int BIT_CLK_GEN1 = 0;
    localparam int BIT_CLK_GEN2 = 1;
    localparam int BIT_CLK_GEN3 = 2;
    localparam int BIT_SER_IN = 3;
    localparam int BIT_SER_OUT = 4;
    localparam int BIT_SRC_BANK0 = 5;
    localparam int BIT_SRC_BANK1 = 6;
    // field positions of the second power gate register
    localparam int BIT_PDM_MIC = 0;
    localparam int BIT_SPDIF_RX = 1;
    localparam int BIT_SPDIF_TX = 2;
    localparam int BIT_AUX_ADC = 3;

    // field positions of the status register
    localparam int BIT_STAT_SPI = 0;
    localparam int BIT_STAT_LOCK = 1;
    localparam int BIT_STAT_CNT_LO = 2;

    // mode switch sequence
    localparam int SS_FALLS_FOR_SPI = 3;
    localparam logic [1:0] SS_CNT_RESET = 2'h0;
    localparam int SRC_CHANNELS_PER_BANK = 8;

    typedef enum logic {MODE_I2C, MODE_SPI} rgpms_mode_e;

    // one register or memory access decoded by the protocol engine
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } rgpms_req_s;

    // clock enables of the optional blocks, plus the core enable, set whenever reset is released
    typedef struct packed {
        logic clk_gen1;
        logic clk_gen2;
        logic clk_gen3;
        logic ser_in;
        logic ser_out;
        logic src_bank0;
        logic src_bank1;
        logic pdm_mic;
        logic spdif_rx;
        logic spdif_tx;
        logic aux_adc;
        logic core;
    } rgpms_gate_s;
endpackage
`default_nettype wire

//--- rtl/rgpms_sync.sv
`default_nettype none
// two-stage synchroniser for a group of independent levels
module rgpms_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule
`default_nettype wire

//--- rtl/rgpms_top.sv
// Contract
// - active-low reset input forces full reset
// - reset held low disables every block
// - registers hold defaults after reset release
// - memory contents untouched by reset
// - boots with reset tied permanently high; the code loads its register defaults and I2C mode only while i_rst_n is low
// - each optional block has own clock gate
// - first register gates clocks, ports, converters
// - second register gates mic, S/PDIF, ADC
// - converters gated in two eight-channel banks
// - port starts in I2C mode after reset
// - three slave-select falls switch to SPI
// - before lock only PLL registers accepted
// - after lock all registers and RAM open
// - external master reads, writes memory, registers
// - never I2C and SPI at once
// - registers sixteen bits, memory words thirty-two
`default_nettype none
module rgpms_top #(
    parameter logic [15:0] PG0_RESET = rgpms_pkg::RST_POWER_GATE_CLOCKS_PORTS_SRC,
    parameter logic [15:0] PG1_RESET = rgpms_pkg::RST_POWER_GATE_MIC_SPDIF_ADC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_select_or_addr_bit_pin,
    input wire logic i_crystal_master_clock_input,
    input wire logic i_pll_locked,
    input wire rgpms_pkg::rgpms_req_s i_req,
    output rgpms_pkg::rgpms_req_s o_fwd,
    output logic o_fwd_is_mem,
    output logic o_rsp_valid,
    output logic [31:0] o_rsp_rdata,
    output logic o_req_ignored,
    output logic o_i2c_enable,
    output logic o_spi_enable,
    output rgpms_pkg::rgpms_gate_s o_gate
);
    import rgpms_pkg::*;

    logic [2:0] sync_in;
    logic ss_s;
    logic mclk_s;
    logic lock_s;
    logic ss_d_ff;
    logic mclk_d_ff;
    logic ss_fall;
    logic mclk_rise;
    logic low_open_ff;
    logic [1:0] ss_cnt_ff;
    rgpms_mode_e mode_ff;
    logic [15:0] pg0_ff;
    logic [15:0] pg1_ff;
    logic in_pll;
    logic is_mem;
    logic is_local;
    logic allowed;
    logic [15:0] rd_local;
    logic [15:0] status;

    // pin and analog inputs cross into the reference clock domain
    rgpms_sync #(.WIDTH(3)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async({~i_select_or_addr_bit_pin, i_crystal_master_clock_input, i_pll_locked}),
        .o_sync(sync_in)
    );

    // select travels inverted, so the cleared synchroniser reads as the idle-high pin
    // and no false fall follows reset
    assign ss_s = !sync_in[2];
    assign mclk_s = sync_in[1];
    assign lock_s = sync_in[0];

    // edge detection on synchronised levels
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ss_d_ff <= 1'b1;
            mclk_d_ff <= 1'b0;
        end else begin
            ss_d_ff <= ss_s;
            mclk_d_ff <= mclk_s;
        end
    end

    assign ss_fall = ss_d_ff && !ss_s;
    assign mclk_rise = !mclk_d_ff && mclk_s;

    // a low pulse counts once a master clock edge is seen during it
    // a fall wins over a clear that lands in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_open_ff <= 1'b0;
        end else if (ss_fall) begin
            low_open_ff <= 1'b1;
        end else if (ss_s || mclk_rise) begin
            low_open_ff <= 1'b0;
        end
    end

    // count qualified falls, latch spi on the third until reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ss_cnt_ff <= SS_CNT_RESET;
            mode_ff <= MODE_I2C;
        end else begin
            case (mode_ff)
                MODE_I2C: begin
                    if (low_open_ff && !ss_s && mclk_rise) begin
                        if (ss_cnt_ff == 2'(SS_FALLS_FOR_SPI - 1)) begin
                            mode_ff <= MODE_SPI;
                        end
                        ss_cnt_ff <= ss_cnt_ff + 2'h1;
                    end
                end
                MODE_SPI: begin
                    mode_ff <= MODE_SPI;
                end
                default: begin
                    mode_ff <= MODE_I2C;
                end
            endcase
        end
    end

    // exactly one protocol engine enabled after reset, none while reset is held
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_i2c_enable <= 1'b0;
            o_spi_enable <= 1'b0;
        end else begin
            o_i2c_enable <= (mode_ff == MODE_I2C);
            o_spi_enable <= (mode_ff == MODE_SPI);
        end
    end

    // address classification and lock gating
    // lock is trusted only after the synchroniser, so early requests are refused
    assign in_pll = (i_req.addr >= ADDR_PLL_FIRST) && (i_req.addr <= ADDR_PLL_LAST);
    assign is_mem = (i_req.addr < ADDR_CTRL_BASE);
    assign is_local = (i_req.addr == ADDR_POWER_GATE_CLOCKS_PORTS_SRC)
                   || (i_req.addr == ADDR_POWER_GATE_MIC_SPDIF_ADC)
                   || (i_req.addr == ADDR_SEQ_STATUS);
    assign allowed = in_pll || lock_s;

    // power gate registers, written only once the pll is locked
    // writes to the status word are dropped without an answer
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pg0_ff <= PG0_RESET;
            pg1_ff <= PG1_RESET;
        end else if (i_req.valid && i_req.write && allowed) begin
            if (i_req.addr == ADDR_POWER_GATE_CLOCKS_PORTS_SRC) begin
                pg0_ff <= i_req.wdata[15:0] & MASK_POWER_GATE_CLOCKS_PORTS_SRC;
            end
            if (i_req.addr == ADDR_POWER_GATE_MIC_SPDIF_ADC) begin
                pg1_ff <= i_req.wdata[15:0] & MASK_POWER_GATE_MIC_SPDIF_ADC;
            end
        end
    end

    // read mux for the locally held registers
    assign status = {13'h0000, ss_cnt_ff[0], lock_s, (mode_ff == MODE_SPI)};
    always_comb begin
        rd_local = 16'h0000;
        case (i_req.addr)
            ADDR_POWER_GATE_CLOCKS_PORTS_SRC: rd_local = pg0_ff;
            ADDR_POWER_GATE_MIC_SPDIF_ADC: rd_local = pg1_ff;
            ADDR_SEQ_STATUS: rd_local = status;
            default: rd_local = 16'h0000;
        endcase
    end

    // local answers, refusals and forwarding to the rest of the map
    // a refused access touches neither the registers nor the forward path
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwd <= '0;
            o_fwd_is_mem <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 32'h0000_0000;
            o_req_ignored <= 1'b0;
        end else begin
            o_fwd <= '0;
            o_rsp_valid <= 1'b0;
            o_req_ignored <= i_req.valid && !allowed;
            if (i_req.valid && allowed) begin
                if (is_local) begin
                    o_rsp_valid <= !i_req.write;
                    o_rsp_rdata <= {16'h0000, rd_local};
                end else begin
                    o_fwd <= i_req;
                    o_fwd_is_mem <= is_mem;
                end
            end
        end
    end

    // clock enables, all off while reset is held; memory has no reset path
    // each enable leaves its own flip-flop, one edge behind the register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_gate <= '0;
        end else begin
            o_gate.clk_gen1 <= pg0_ff[BIT_CLK_GEN1];
            o_gate.clk_gen2 <= pg0_ff[BIT_CLK_GEN2];
            o_gate.clk_gen3 <= pg0_ff[BIT_CLK_GEN3];
            o_gate.ser_in <= pg0_ff[BIT_SER_IN];
            o_gate.ser_out <= pg0_ff[BIT_SER_OUT];
            o_gate.src_bank0 <= pg0_ff[BIT_SRC_BANK0];
            o_gate.src_bank1 <= pg0_ff[BIT_SRC_BANK1];
            o_gate.pdm_mic <= pg1_ff[BIT_PDM_MIC];
            o_gate.spdif_rx <= pg1_ff[BIT_SPDIF_RX];
            o_gate.spdif_tx <= pg1_ff[BIT_SPDIF_TX];
            o_gate.aux_adc <= pg1_ff[BIT_AUX_ADC];
            o_gate.core <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- sim/rgpms_chk_asserts.sv
`default_nettype none
module rgpms_chk_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_pll_locked,
    input wire rgpms_pkg::rgpms_req_s i_req,
    input wire rgpms_pkg::rgpms_req_s o_fwd,
    input wire logic o_fwd_is_mem,
    input wire logic o_rsp_valid,
    input wire logic [31:0] o_rsp_rdata,
    input wire logic o_req_ignored,
    input wire logic o_i2c_enable,
    input wire logic o_spi_enable,
    input wire rgpms_pkg::rgpms_gate_s o_gate
);
    import rgpms_pkg::*;
    logic [2:0] lk_ff;
    wire pll_req = i_req.valid && i_req.addr >= ADDR_PLL_FIRST && i_req.addr <= ADDR_PLL_LAST;
    wire lk_hi = i_pll_locked && &lk_ff;
    wire lk_lo = !i_pll_locked && ~|lk_ff;
    // lock history, so the synchroniser delay is covered
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_ff <= 3'h0;
        end else begin
            lk_ff <= {lk_ff[1:0], i_pll_locked};
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rst;
        disable iff (1'b0)
        !i_rst_n && !$past(i_rst_n) |-> o_gate == '0 && !o_i2c_enable && !o_spi_enable;
    endproperty
    a_rst: assert property (p_rst) else $error("block active in reset");
    property p_first;
        $rose(i_rst_n) |=> o_i2c_enable && !o_spi_enable && o_gate.core;
    endproperty
    a_first: assert property (p_first) else $error("bad state after reset");
    property p_excl;
        $past(i_rst_n) |-> o_i2c_enable != o_spi_enable;
    endproperty
    a_excl: assert property (p_excl) else $error("protocols not exclusive");
    property p_ign;
        lk_lo && i_req.valid && !pll_req |=> o_req_ignored && !o_fwd.valid;
    endproperty
    a_ign: assert property (p_ign) else $error("unlocked access not dropped");
    property p_pll;
        pll_req |=> o_fwd.valid && !o_req_ignored && o_fwd.addr == $past(i_req.addr);
    endproperty
    a_pll: assert property (p_pll) else $error("pll access not forwarded");
    property p_mem;
        lk_hi && i_req.valid && i_req.addr < ADDR_CTRL_BASE
            |=> o_fwd.valid && o_fwd_is_mem && o_fwd.wdata == $past(i_req.wdata);
    endproperty
    a_mem: assert property (p_mem) else $error("memory access lost");
    property p_rd;
        lk_hi && i_req.valid && !i_req.write && i_req.addr == ADDR_POWER_GATE_CLOCKS_PORTS_SRC
            |=> o_rsp_valid && o_rsp_rdata[31:7] == '0;
    endproperty
    a_rd: assert property (p_rd) else $error("bad register read");
    property p_gate;
        lk_hi && i_req.valid && i_req.write && i_req.addr == ADDR_POWER_GATE_CLOCKS_PORTS_SRC
            |=> ##1 o_gate.src_bank0 == $past(i_req.wdata[BIT_SRC_BANK0], 2)
            && o_gate.src_bank1 == $past(i_req.wdata[BIT_SRC_BANK1], 2);
    endproperty
    a_gate: assert property (p_gate) else $error("converter bank gate wrong");
    property p_spi; o_spi_enable |=> o_spi_enable; endproperty
    a_spi: assert property (p_spi) else $error("spi mode lost");
endmodule
`default_nettype wire

//--- sim/rgpms_host_model.sv
`default_nettype none
module rgpms_host_model (
    input wire logic i_ref_clk,
    output logic o_mclk,
    output logic o_ss
);
    timeunit 1ns;
    timeprecision 1ps;
    // free running master clock, phase offset from the system clock
    initial begin
        o_mclk = 1'b0;
        o_ss = 1'b1;
        #7;
        forever #80 o_mclk = ~o_mclk;
    end
    // select low pulse, long enough to span a master clock rise when qual
    task automatic ss_pulse(input bit qual);
        @(posedge o_mclk);
        @(negedge i_ref_clk);
        o_ss = 1'b0;
        repeat (qual ? 10 : 2) @(negedge i_ref_clk);
        o_ss = 1'b1;
        repeat (10) @(negedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rgpms_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lock = 1'b0;
    logic mclk, ss, is_mem, rv, ign, i2c, spi;
    logic [31:0] rd, d;
    logic [15:0] a, pg0, pg1;
    rgpms_req_s req = '0;
    rgpms_req_s fwd;
    rgpms_gate_s gate;
    int fails = 0;
    int samples_checked = 0;
    initial forever #10 clk = ~clk;
    rgpms_host_model host (.i_ref_clk(clk), .o_mclk(mclk), .o_ss(ss));
    rgpms_top uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_select_or_addr_bit_pin(ss),
        .i_crystal_master_clock_input(mclk), .i_pll_locked(lock), .i_req(req), .o_fwd(fwd),
        .o_fwd_is_mem(is_mem), .o_rsp_valid(rv), .o_rsp_rdata(rd), .o_req_ignored(ign),
        .o_i2c_enable(i2c), .o_spi_enable(spi), .o_gate(gate));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    // one access, outputs stand in the cycle after it is taken
    task acc(input logic w, input logic [15:0] ad, input logic [31:0] wd);
        @(negedge clk);
        req = '{1'b1, w, ad, wd};
        @(negedge clk);
        req.valid = 1'b0;
    endtask
    task rst();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        pg0 = RST_POWER_GATE_CLOCKS_PORTS_SRC;
        pg1 = RST_POWER_GATE_MIC_SPDIF_ADC;
        repeat (4) @(negedge clk);
    endtask
    function automatic rgpms_gate_s exp_gate();
        return '{pg0[0], pg0[1], pg0[2], pg0[3], pg0[4], pg0[5], pg0[6],
            pg1[0], pg1[1], pg1[2], pg1[3], 1'b1};
    endfunction
    task conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        conclude();
    end
    initial begin
        void'($urandom(95739));
        rst();
        a = ADDR_PLL_FIRST + 16'($urandom_range(4));
        acc(1'b0, a, 32'h0);
        chk("pll fwd", fwd.valid, 1);
        chk("pll addr", {16'h0, fwd.addr}, {16'h0, a});
        chk("pll not mem", is_mem, 0);
        chk("not ignored", ign, 0);
        acc(1'b1, ADDR_POWER_GATE_CLOCKS_PORTS_SRC, 32'h0);
        chk("ignored", ign, 1);
        chk("no fwd", fwd.valid, 0);
        $display("test unlocked done");
        lock = 1'b1;
        repeat (4) @(negedge clk);
        acc(1'b0, ADDR_POWER_GATE_CLOCKS_PORTS_SRC, 32'h0);
        chk("pg0", rd, {16'h0, pg0});
        chk("rsp valid", rv, 1);
        acc(1'b0, ADDR_POWER_GATE_MIC_SPDIF_ADC, 32'h0);
        chk("pg1", rd, {16'h0, pg1});
        chk("gate", {20'h0, gate}, {20'h0, exp_gate()});
        for (int i = 0; i < 20; i++) begin
            d = $urandom;
            a = ADDR_POWER_GATE_CLOCKS_PORTS_SRC + 16'(i % 2);
            acc(1'b1, a, d);
            if (i % 2 == 0) pg0 = d[15:0] & MASK_POWER_GATE_CLOCKS_PORTS_SRC;
            else pg1 = d[15:0] & MASK_POWER_GATE_MIC_SPDIF_ADC;
            repeat (2) @(negedge clk);
            chk("gate", {20'h0, gate}, {20'h0, exp_gate()});
            acc(1'b0, a, 32'h0);
            chk("readback", rd, {16'h0, (i % 2 == 0) ? pg0 : pg1});
        end
        $display("test gates done");
        d = $urandom;
        a = 16'($urandom_range(16'hefff));
        acc(1'b1, a, d);
        chk("mem", is_mem, 1);
        chk("mem fwd", fwd.valid, 1);
        chk("mem data", fwd.wdata, d);
        acc(1'b0, ADDR_SEQ_STATUS, 32'h0);
        chk("status", rd, 32'h2);
        lock = 1'b0;
        repeat (4) @(negedge clk);
        acc(1'b1, ADDR_POWER_GATE_CLOCKS_PORTS_SRC, 32'h0);
        chk("ignored", ign, 1);
        lock = 1'b1;
        repeat (4) @(negedge clk);
        acc(1'b0, ADDR_POWER_GATE_CLOCKS_PORTS_SRC, 32'h0);
        chk("kept", rd, {16'h0, pg0});
        $display("test lock done");
        host.ss_pulse(1'b0);
        host.ss_pulse(1'b1);
        host.ss_pulse(1'b1);
        chk("spi early", spi, 0);
        host.ss_pulse(1'b1);
        chk("spi", spi, 1);
        chk("i2c off", i2c, 0);
        acc(1'b0, ADDR_SEQ_STATUS, 32'h0);
        chk("status spi", rd, 32'h7);
        $display("test mode done");
        rst();
        chk("i2c", i2c, 1);
        chk("spi off", spi, 0);
        chk("gate", {20'h0, gate}, {20'h0, exp_gate()});
        $display("test rereset done");
        conclude();
    end
endmodule
bind rgpms_top rgpms_chk_asserts chk (.i_ref_clk, .i_rst_n, .i_pll_locked, .i_req, .o_fwd,
    .o_fwd_is_mem, .o_rsp_valid, .o_rsp_rdata, .o_req_ignored, .o_i2c_enable, .o_spi_enable,
    .o_gate);
`default_nettype wire
